// ### adc_out_mux.sv
// Output formatter of a two channel sampling converter: full rate and DDR outputs
`default_nettype none

module adc_out_mux (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_clk_in,
  input wire logic [adc_out_pkg::WORD_W-1:0] ch1_sample_in,
  input wire logic ch1_over_in,
  input wire logic [adc_out_pkg::WORD_W-1:0] ch2_sample_in,
  input wire logic ch2_over_in,
  input wire logic [adc_out_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_out_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adc_out_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic fwd_clk_true,
  output logic fwd_clk_comp,
  output logic [adc_out_pkg::WORD_W-1:0] ch1_word_out,
  output logic [adc_out_pkg::LANE_W-1:0] ch1_pair_lane,
  output logic ch1_range_flag,
  output logic [adc_out_pkg::WORD_W-1:0] ch2_word_out,
  output logic [adc_out_pkg::LANE_W-1:0] ch2_pair_lane,
  output logic ch2_range_flag,
  output logic combined_range_flag,
  output logic lvds_mode_en,
  output logic [adc_out_pkg::CUR_W-1:0] lvds_current_sel,
  output logic lvds_term_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int SMP_W = adc_out_pkg::WORD_W + 1;

  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic base_ff;
  logic [SMP_W-1:0] in1_s1_ff;
  logic [SMP_W-1:0] in1_s2_ff;
  logic [SMP_W-1:0] in2_s1_ff;
  logic [SMP_W-1:0] in2_s2_ff;
  logic [SMP_W-1:0] hold1_ff;
  logic [SMP_W-1:0] hold2_ff;
  localparam int TAP_W = adc_out_pkg::TAP_DEPTH;
  logic [TAP_W-1:0] taps_ff;

  adc_out_pkg::out_fmt_t fmt_ff;
  logic [adc_out_pkg::DLY_W-1:0] dly_ff;
  logic term_ff;
  logic [adc_out_pkg::STAT_W-1:0] status_ff;
  logic [adc_out_pkg::STAT_W-1:0] mask_ff;

  logic rise_w;
  logic fall_w;
  logic ddr_w;
  logic lvds_w;
  logic nxt_fwd;
  logic nxt_comb;
  logic wr_ctrl_w;
  logic wr_mask_w;
  logic rd_status_w;
  logic [adc_out_pkg::STAT_W-1:0] set_w;
  logic [adc_out_pkg::STAT_W-1:0] nxt_status;
  logic [adc_out_pkg::DATA_W-1:0] ctrl_rd_w;
  logic [adc_out_pkg::DATA_W-1:0] sample_rd_w;
  logic [adc_out_pkg::DATA_W-1:0] nxt_rdata;

  chan_if c1 ();
  chan_if c2 ();

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: sample clock and converter words come from outside clk

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      base_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= sample_clk_in;
      sclk_s2_ff <= sclk_s1_ff;
      base_ff <= sclk_s2_ff;
    end
  end

  // Words settle well before the sample edge is seen, so a plain two stage
  // capture is safe as long as the sample period spans several clk cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in1_s1_ff <= '0;
      in1_s2_ff <= '0;
      in2_s1_ff <= '0;
      in2_s2_ff <= '0;
    end else begin
      in1_s1_ff <= {ch1_over_in, ch1_sample_in};
      in1_s2_ff <= in1_s1_ff;
      in2_s1_ff <= {ch2_over_in, ch2_sample_in};
      in2_s2_ff <= in2_s1_ff;
    end
  end

  assign rise_w = sclk_s2_ff & ~base_ff;
  assign fall_w = ~sclk_s2_ff & base_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture: one edge takes both channels

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold1_ff <= '0;
      hold2_ff <= '0;
    end else if (rise_w) begin
      hold1_ff <= in1_s2_ff;
      hold2_ff <= in2_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel formatters: load on the falling half, odd bits on the rising half

  assign ddr_w = (fmt_ff == adc_out_pkg::FMT_DDR_CMOS) || (fmt_ff == adc_out_pkg::FMT_DDR_LVDS);
  assign lvds_w = fmt_ff == adc_out_pkg::FMT_DDR_LVDS;

  assign c1.word = hold1_ff[adc_out_pkg::WORD_W-1:0];
  assign c1.ovr = hold1_ff[adc_out_pkg::WORD_W];
  assign c1.load = fall_w;
  assign c1.odd = rise_w;
  assign c1.ddr = ddr_w;
  assign c2.word = hold2_ff[adc_out_pkg::WORD_W-1:0];
  assign c2.ovr = hold2_ff[adc_out_pkg::WORD_W];
  assign c2.load = fall_w;
  assign c2.odd = rise_w;
  assign c2.ddr = ddr_w;

  chan_formatter u_ch1 (
    .clk(clk),
    .reset_n(reset_n),
    .link(c1),
    .word_out(ch1_word_out),
    .pair_lane(ch1_pair_lane),
    .range_flag(ch1_range_flag)
  );

  chan_formatter u_ch2 (
    .clk(clk),
    .reset_n(reset_n),
    .link(c2),
    .word_out(ch2_word_out),
    .pair_lane(ch2_pair_lane),
    .range_flag(ch2_range_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Combined flag: channel 2 in the low half, channel 1 in the high half

  assign nxt_comb = !ddr_w ? 1'b0 :
                    fall_w ? hold2_ff[adc_out_pkg::WORD_W] :
                    rise_w ? c1.out_ovr : combined_range_flag;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      combined_range_flag <= 1'b0;
    end else begin
      combined_range_flag <= nxt_comb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarded clock: the sample phase, optionally held back by a few taps

  // Delay steps are one clk period; coarse, but enough to move the receiver's
  // capture point off the data transitions
  assign nxt_fwd = (dly_ff == '0) ? sclk_s2_ff : taps_ff[dly_ff - 2'd1];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      taps_ff <= '0;
      fwd_clk_true <= 1'b0;
      fwd_clk_comp <= 1'b1;
    end else begin
      taps_ff <= {taps_ff[TAP_W-2:0], sclk_s2_ff};
      fwd_clk_true <= nxt_fwd;
      fwd_clk_comp <= ~nxt_fwd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign wr_ctrl_w = reg_wr && (reg_addr == adc_out_pkg::CTRL_OFS);
  assign wr_mask_w = reg_wr && (reg_addr == adc_out_pkg::MASK_OFS);
  assign rd_status_w = reg_rd && (reg_addr == adc_out_pkg::STATUS_OFS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt_ff <= adc_out_pkg::FMT_FULL_CMOS;
      dly_ff <= adc_out_pkg::DLY_RST;
      lvds_current_sel <= adc_out_pkg::CUR_RST;
      term_ff <= adc_out_pkg::TERM_RST;
      mask_ff <= adc_out_pkg::MASK_RST;
    end else begin
      if (wr_ctrl_w) begin
        fmt_ff <= adc_out_pkg::out_fmt_t'(reg_wdata[adc_out_pkg::CTRL_FMT_LSB +: adc_out_pkg::FMT_W]);
        dly_ff <= reg_wdata[adc_out_pkg::CTRL_DLY_LSB +: adc_out_pkg::DLY_W];
        lvds_current_sel <= reg_wdata[adc_out_pkg::CTRL_CUR_LSB +: adc_out_pkg::CUR_W];
        term_ff <= reg_wdata[adc_out_pkg::CTRL_TERM_BIT];
      end
      if (wr_mask_w) begin
        mask_ff <= reg_wdata[adc_out_pkg::STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvds_mode_en <= 1'b0;
      lvds_term_en <= 1'b0;
    end else begin
      lvds_mode_en <= lvds_w;
      lvds_term_en <= lvds_w & term_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt: a new event beats the clear of the same read

  assign set_w[adc_out_pkg::STAT_CH1_OVR] = rise_w & in1_s2_ff[adc_out_pkg::WORD_W];
  assign set_w[adc_out_pkg::STAT_CH2_OVR] = rise_w & in2_s2_ff[adc_out_pkg::WORD_W];
  assign set_w[adc_out_pkg::STAT_SAMPLE] = rise_w;
  assign nxt_status = (status_ff & ~{adc_out_pkg::STAT_W{rd_status_w}}) | set_w;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= '0;
      irq <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq <= |(nxt_status & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: valid only in the cycle after the read strobe

  assign ctrl_rd_w = adc_out_pkg::DATA_W'({term_ff, lvds_current_sel, dly_ff, fmt_ff});
  assign sample_rd_w = {3'h0, hold2_ff, 3'h0, hold1_ff};
  assign nxt_rdata = !reg_rd ? '0 :
                     (reg_addr == adc_out_pkg::CTRL_OFS) ? ctrl_rd_w :
                     (reg_addr == adc_out_pkg::STATUS_OFS) ? adc_out_pkg::DATA_W'(status_ff) :
                     (reg_addr == adc_out_pkg::MASK_OFS) ? adc_out_pkg::DATA_W'(mask_ff) :
                     (reg_addr == adc_out_pkg::SAMPLE_OFS) ? sample_rd_w : '0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_comp_clock_inverse: assert property (
    fwd_clk_comp == !fwd_clk_true)
    else $error("complement clock not inverse");
  a_clk_no_delay: assert property (
    dly_ff == '0 && $past(dly_ff) == '0 |-> fwd_clk_true == base_ff)
    else $error("undelayed clock not aligned to data");
  a_clk_delay_two: assert property (
    dly_ff == 2'h2 && $past(dly_ff) == 2'h2 && $past(dly_ff, 2) == 2'h2 |-> fwd_clk_true == $past(base_ff, 2))
    else $error("clock delay of two taps wrong");
  a_capture_both: assert property (
    rise_w |=> hold1_ff == $past(in1_s2_ff) && hold2_ff == $past(in2_s2_ff))
    else $error("channels not captured together");
  a_comb_flag_low: assert property (
    $past(fall_w) && $past(ddr_w) && ddr_w |->
      combined_range_flag == c2.out_ovr && ((!fwd_clk_true) ^ ($past(dly_ff) != '0)))
    else $error("combined flag not channel 2 in low half");
  a_comb_flag_high: assert property (
    $past(rise_w) && $past(ddr_w) && ddr_w |-> combined_range_flag == c1.out_ovr)
    else $error("combined flag not channel 1 in high half");
  a_status_sticky: assert property (
    rise_w && in1_s2_ff[adc_out_pkg::WORD_W] |=> status_ff[adc_out_pkg::STAT_CH1_OVR] [*2] or
      (status_ff[adc_out_pkg::STAT_CH1_OVR] ##1 $past(rd_status_w)))
    else $error("range event lost");
  a_term_lvds_only: assert property (
    lvds_term_en |-> lvds_mode_en && $past(term_ff))
    else $error("termination outside LVDS mode");
  a_mode_follow: assert property (
    $past(wr_ctrl_w, 2) |-> lvds_mode_en ==
      ($past(reg_wdata[adc_out_pkg::CTRL_FMT_LSB +: adc_out_pkg::FMT_W], 2) == 2'h2))
    else $error("format write not applied");
  a_irq_level: assert property (
    irq == |(status_ff & $past(mask_ff)))
    else $error("interrupt level wrong");

  c_lvds_frame: cover property (lvds_w && rise_w ##[1:20] fall_w);
  c_delay_max: cover property (dly_ff == 2'h3 && rise_w);
  c_irq_raised: cover property (!irq ##1 irq);
  c_full_overrange: cover property (!ddr_w && fall_w && hold1_ff[adc_out_pkg::WORD_W]);

endmodule : adc_out_mux

`default_nettype wire

// ### adc_out_pkg.sv
// Constants and types shared by the dual converter output formatter
`default_nettype none

package adc_out_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int WORD_W = 12;
  localparam int LANE_W = 6;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int DLY_W = 2;
  localparam int CUR_W = 3;
  localparam int FMT_W = 2;
  localparam int STAT_W = 3;
  localparam int TAP_DEPTH = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] SAMPLE_OFS = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_DLY_LSB = 2;
  localparam int CTRL_CUR_LSB = 4;
  localparam int CTRL_TERM_BIT = 7;
  localparam int STAT_CH1_OVR = 0;
  localparam int STAT_CH2_OVR = 1;
  localparam int STAT_SAMPLE = 2;
  localparam int SAMPLE_OVR1_BIT = 12;
  localparam int SAMPLE_CH2_LSB = 16;
  localparam int SAMPLE_OVR2_BIT = 28;

  ////////////////////////////////////////////////////////////////////////////
  // Output formats and reset values
  typedef enum logic [FMT_W-1:0] {FMT_FULL_CMOS, FMT_DDR_CMOS, FMT_DDR_LVDS} out_fmt_t;

  localparam logic [DLY_W-1:0] DLY_RST = 2'h0;
  // Level 4 of the eight drive codes, the standard signalling current
  localparam logic [CUR_W-1:0] CUR_RST = 3'h4;
  localparam logic TERM_RST = 1'b0;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

endpackage : adc_out_pkg

`default_nettype wire

// ### chan_formatter.sv
// One channel's output word, paired lanes and range flag
`default_nettype none

module chan_formatter (
  input wire logic clk,
  input wire logic reset_n,
  chan_if.fmt link,
  output logic [adc_out_pkg::WORD_W-1:0] word_out,
  output logic [adc_out_pkg::LANE_W-1:0] pair_lane,
  output logic range_flag
);

  logic [adc_out_pkg::WORD_W-1:0] out_word_ff;
  logic out_ovr_ff;
  logic [adc_out_pkg::LANE_W-1:0] even_w;
  logic [adc_out_pkg::LANE_W-1:0] odd_w;
  logic [adc_out_pkg::WORD_W-1:0] nxt_word_out;
  logic [adc_out_pkg::LANE_W-1:0] nxt_lane;
  logic nxt_flag;

  for (genvar k = 0; k < adc_out_pkg::LANE_W; k++) begin : g_pair
    assign even_w[k] = link.word[2*k];
    assign odd_w[k] = out_word_ff[2*k+1];
  end

  assign nxt_word_out = link.ddr ? '0 : (link.load ? link.word : word_out);
  assign nxt_lane = !link.ddr ? '0 : (link.load ? even_w : (link.odd ? odd_w : pair_lane));
  assign nxt_flag = link.ddr ? 1'b0 : (link.load ? link.ovr : range_flag);
  assign link.out_ovr = out_ovr_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_word_ff <= '0;
      out_ovr_ff <= 1'b0;
      word_out <= '0;
      pair_lane <= '0;
      range_flag <= 1'b0;
    end else begin
      if (link.load) begin
        out_word_ff <= link.word;
        out_ovr_ff <= link.ovr;
      end
      word_out <= nxt_word_out;
      pair_lane <= nxt_lane;
      range_flag <= nxt_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ddr_even_low: assert property (
    $past(link.load) && $past(link.ddr) && link.ddr |-> pair_lane == {
      out_word_ff[10], out_word_ff[8], out_word_ff[6], out_word_ff[4], out_word_ff[2], out_word_ff[0]})
    else $error("even bits not on lanes in low half");
  a_ddr_odd_high: assert property (
    $past(link.odd) && !$past(link.load) && $past(link.ddr) && link.ddr |-> pair_lane == odd_w)
    else $error("odd bits not on lanes in high half");
  a_full_word_out: assert property (
    $past(link.load) && !$past(link.ddr) |-> word_out == out_word_ff && pair_lane == '0)
    else $error("full rate word not presented");
  a_own_flag_full: assert property (
    $past(link.load) && !$past(link.ddr) |-> range_flag == $past(link.ovr))
    else $error("dedicated range flag wrong");
  a_flag_word_aligned: assert property (
    $past(link.load) |-> out_ovr_ff == $past(link.ovr) && out_word_ff == $past(link.word))
    else $error("flag and word loaded apart");

endmodule : chan_formatter

`default_nettype wire

// ### chan_if.sv
// Link between the shared timing logic and one channel formatter
`default_nettype none

interface chan_if;
  logic [adc_out_pkg::WORD_W-1:0] word;
  logic ovr;
  logic load;
  logic odd;
  logic ddr;
  logic out_ovr;

  modport fmt (input word, input ovr, input load, input odd, input ddr, output out_ovr);
  modport ctl (output word, output ovr, output load, output odd, output ddr, input out_ovr);
endinterface : chan_if

`default_nettype wire

// ### dual_adc_ddr_output_mux_tb_top.sv
// Self-checking bench for the dual converter output formatter
`default_nettype none

module dual_adc_ddr_output_mux_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset_n;
  logic sample_clk_in;
  logic [11:0] ch1_sample_in, ch2_sample_in, ch1_word_out, ch2_word_out, rx_w1, rx_w2;
  logic ch1_over_in, ch2_over_in, reg_wr, reg_rd, irq, fwd_clk_true, fwd_clk_comp;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [5:0] ch1_pair_lane, ch2_pair_lane;
  logic ch1_range_flag, ch2_range_flag, combined_range_flag, lvds_mode_en, lvds_term_en;
  logic [2:0] lvds_current_sel, cur;
  logic rx_valid, rx_f1, rx_f2, ddr_mode, term, f1, f2;
  logic [1:0] fmt, dly;
  logic [11:0] w1, w2;
  logic [11:0] corner [4] = '{12'h000, 12'hfff, 12'haaa, 12'h555};
  int error_cnt, n_tests, cyc;

  adc_out_mux dut (.clk(clk), .reset_n(reset_n), .sample_clk_in(sample_clk_in),
    .ch1_sample_in(ch1_sample_in), .ch1_over_in(ch1_over_in), .ch2_sample_in(ch2_sample_in),
    .ch2_over_in(ch2_over_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .fwd_clk_true(fwd_clk_true),
    .fwd_clk_comp(fwd_clk_comp), .ch1_word_out(ch1_word_out), .ch1_pair_lane(ch1_pair_lane),
    .ch1_range_flag(ch1_range_flag), .ch2_word_out(ch2_word_out), .ch2_pair_lane(ch2_pair_lane),
    .ch2_range_flag(ch2_range_flag), .combined_range_flag(combined_range_flag),
    .lvds_mode_en(lvds_mode_en), .lvds_current_sel(lvds_current_sel), .lvds_term_en(lvds_term_en));

  link_rx_model rx (.clk(clk), .reset_n(reset_n), .ddr_mode(ddr_mode), .fwd_clk_true(fwd_clk_true),
    .ch1_word_out(ch1_word_out), .ch2_word_out(ch2_word_out), .ch1_pair_lane(ch1_pair_lane),
    .ch2_pair_lane(ch2_pair_lane), .ch1_range_flag(ch1_range_flag), .ch2_range_flag(ch2_range_flag),
    .combined_range_flag(combined_range_flag), .rx_valid(rx_valid), .rx_w1(rx_w1), .rx_w2(rx_w2),
    .rx_f1(rx_f1), .rx_f2(rx_f2));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Odd start offset keeps the sample clock out of phase with clk
  initial begin
    sample_clk_in = 1'b0;
    #3.3;
    forever #62.5 sample_clk_in = ~sample_clk_in;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_ctrl(input logic [1:0] f, input logic [1:0] d, input logic [2:0] c,
                                           input logic t);
    return {24'h0, t, c, d, f};
  endfunction : exp_ctrl

  function automatic logic [31:0] exp_sample(input logic [11:0] a, input logic fa, input logic [11:0] b,
                                             input logic fb);
    return {3'h0, fb, b, 3'h0, fa, a};
  endfunction : exp_sample

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Bounded wait for n words rebuilt by the receiver
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 400) begin
      @(posedge clk);
      k++;
      if (rx_valid === 1'b1) n--;
    end
    if (n > 0) check("word wait", 0, 1);
  endtask : wait_words

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    {ch1_sample_in, ch2_sample_in, ch1_over_in, ch2_over_in} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, ddr_mode} = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(28219));
    repeat (3) @(posedge clk);
    check("reset clocks", 32'h1, {fwd_clk_true, fwd_clk_comp});
    check("reset current", 32'h4, lvds_current_sel);
    reset_n <= 1'b1;
    reg_read(adc_out_pkg::CTRL_OFS, rd);
    check("ctrl reset", exp_ctrl(2'h0, 2'h0, 3'h4, 1'b0), rd);
    reg_read(adc_out_pkg::MASK_OFS, rd);
    check("mask reset", 0, rd);
    reg_read(4'h2, rd);
    check("unmapped read", 0, rd);
    // Every format code, code 3 included, with random delay, drive and data
    for (int i = 0; i < 28; i++) begin
      fmt = 2'(i % 4);
      dly = 2'($urandom_range(3, 0));
      cur = 3'($urandom_range(6, 0));
      term = 1'($urandom_range(1, 0));
      w1 = (i < 4) ? corner[i] : 12'($urandom);
      w2 = (i < 4) ? ~corner[i] : 12'($urandom);
      f1 = 1'($urandom_range(1, 0));
      f2 = 1'($urandom_range(1, 0));
      reg_write(adc_out_pkg::CTRL_OFS, exp_ctrl(fmt, dly, cur, term));
      ddr_mode <= (fmt == 2'h1 || fmt == 2'h2);
      ch1_sample_in <= w1;
      ch2_sample_in <= w2;
      ch1_over_in <= f1;
      ch2_over_in <= f2;
      // A delay change can add a clock pulse and one frame may still be in flight
      wait_words(4);
      check("ch1 word", w1, rx_w1);
      check("ch2 word", w2, rx_w2);
      check("ch1 flag", f1, rx_f1);
      check("ch2 flag", f2, rx_f2);
      check("clock pair", {31'h0, !fwd_clk_true}, fwd_clk_comp);
      if (ddr_mode) check("idle full", 0, {ch1_word_out, ch2_word_out, ch1_range_flag, ch2_range_flag});
      else check("idle lanes", 0, {ch1_pair_lane, ch2_pair_lane, combined_range_flag});
      if (fmt == 2'h2) check("lvds", {1'b1, cur, term}, {lvds_mode_en, lvds_current_sel, lvds_term_en});
      else check("lvds off", 0, {lvds_mode_en, lvds_term_en});
      reg_read(adc_out_pkg::SAMPLE_OFS, rd);
      check("sample reg", exp_sample(w1, f1, w2, f2), rd);
    end
    // Sticky range events, masking and clear on read
    ch1_over_in <= 1'b0;
    ch2_over_in <= 1'b0;
    reg_write(adc_out_pkg::MASK_OFS, 0);
    wait_words(2);
    reg_read(adc_out_pkg::STATUS_OFS, rd);
    ch1_over_in <= 1'b1;
    wait_words(2);
    check("irq masked", 0, irq);
    ch1_over_in <= 1'b0;
    wait_words(2);
    reg_write(adc_out_pkg::MASK_OFS, 32'h1);
    repeat (3) @(posedge clk);
    check("irq raised", 1, irq);
    reg_read(adc_out_pkg::STATUS_OFS, rd);
    check("status", 32'h1, rd[1:0]);
    repeat (3) @(posedge clk);
    check("irq cleared", 0, irq);
    reg_write(adc_out_pkg::MASK_OFS, 32'h4);
    wait_words(2);
    repeat (3) @(posedge clk);
    check("irq sample", 1, irq);
    complete_run();
  end
endmodule : dual_adc_ddr_output_mux_tb_top

`default_nettype wire

// ### link_rx_model.sv
// Receiver model: rebuilds both sample words and range flags from the output link
`default_nettype none

module link_rx_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ddr_mode,
  input wire logic fwd_clk_true,
  input wire logic [adc_out_pkg::WORD_W-1:0] ch1_word_out,
  input wire logic [adc_out_pkg::WORD_W-1:0] ch2_word_out,
  input wire logic [adc_out_pkg::LANE_W-1:0] ch1_pair_lane,
  input wire logic [adc_out_pkg::LANE_W-1:0] ch2_pair_lane,
  input wire logic ch1_range_flag,
  input wire logic ch2_range_flag,
  input wire logic combined_range_flag,
  output logic rx_valid,
  output logic [adc_out_pkg::WORD_W-1:0] rx_w1,
  output logic [adc_out_pkg::WORD_W-1:0] rx_w2,
  output logic rx_f1,
  output logic rx_f2
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fwd_prev_ff;
  logic [adc_out_pkg::LANE_W-1:0] even1_ff;
  logic [adc_out_pkg::LANE_W-1:0] even2_ff;
  logic f2_ff;
  logic fwd_rose;
  logic fwd_fell;

  ////////////////////////////////////////////////////////////////////////////
  // Capture on the forwarded clock edges, which trail the data change by the clock delay setting in clk cycles
  assign fwd_rose = fwd_clk_true & ~fwd_prev_ff;
  assign fwd_fell = ~fwd_clk_true & fwd_prev_ff;

  function automatic logic [adc_out_pkg::WORD_W-1:0] weave(input logic [adc_out_pkg::LANE_W-1:0] ev,
                                                            input logic [adc_out_pkg::LANE_W-1:0] od);
    logic [adc_out_pkg::WORD_W-1:0] w;
    for (int k = 0; k < adc_out_pkg::LANE_W; k++) begin
      w[2*k] = ev[k];
      w[2*k+1] = od[k];
    end
    return w;
  endfunction : weave

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_prev_ff <= 1'b0;
      even1_ff <= '0;
      even2_ff <= '0;
      f2_ff <= 1'b0;
      rx_valid <= 1'b0;
      rx_w1 <= '0;
      rx_w2 <= '0;
      rx_f1 <= 1'b0;
      rx_f2 <= 1'b0;
    end else begin
      fwd_prev_ff <= fwd_clk_true;
      rx_valid <= fwd_rose;
      if (fwd_fell) begin
        even1_ff <= ch1_pair_lane;
        even2_ff <= ch2_pair_lane;
        f2_ff <= combined_range_flag;
      end
      if (fwd_rose && ddr_mode) begin
        rx_w1 <= weave(even1_ff, ch1_pair_lane);
        rx_w2 <= weave(even2_ff, ch2_pair_lane);
        rx_f1 <= combined_range_flag;
        rx_f2 <= f2_ff;
      end else if (fwd_rose) begin
        rx_w1 <= ch1_word_out;
        rx_w2 <= ch2_word_out;
        rx_f1 <= ch1_range_flag;
        rx_f2 <= ch2_range_flag;
      end
    end
  end
endmodule : link_rx_model

`default_nettype wire
